// file: rtl/dsr_pkg.sv
// Shared constants and types for the driver status readback block
package dsr_pkg;
   localparam int STATUS_W = 20;
   localparam int READBACK_SELECT_LSB = 4;
   localparam int STEP_DIS_BIT = 7;
   localparam int ADDR_LSB = 17;
   localparam logic [2:0] ADDR_CHOPPER = 3'h4;
   localparam logic [2:0] ADDR_DRIVER_CONFIGURATION = 3'h7;
   localparam int CHOPPER_OFF_TIME_W = 4;
   localparam logic [1:0] SHORT_LIMIT = 2'h3;
   localparam int STILL_EXP = 20;
   localparam int STILL_W = STILL_EXP + 1;
   localparam logic [19:0] DRIVER_CONFIGURATION_RESET = 20'h00000;
   localparam logic [3:0] CHOPPER_OFF_TIME_RESET = 4'h0;
   localparam logic [19:0] STATUS_RESET = 20'h00000;
   // Idle level of every synchronised pin: frame select high, rest low
   localparam logic [14:0] PINS_RESET = 15'h4000;
   localparam logic [21:0] LINK_TX_IDLE = 22'h000001;

   typedef enum logic [1:0] {
      RD_POSITION,
      RD_LOAD,
      RD_LOAD_SCALE,
      RD_DIAG
   } dsr_readback_select_type;

   typedef struct packed {
      logic frame_n;
      logic step;
      logic disable_drv;
      logic supply_low;
      logic [3:0] temp;
      logic b_supply;
      logic b_ground;
      logic a_supply;
      logic a_ground;
      logic overtemp_warning;
      logic ot;
      logic stall;
   } dsr_pins_type;

   typedef struct packed {
      logic [18:0] rest;
      logic data;
      logic started;
      logic oe_n;
   } dsr_link_tx_type;
endpackage

// file: rtl/dsr_readback.sv
// Status word builder, protection counters and link for the motor driver
`timescale 1ns/1ps
module dsr_readback
   import dsr_pkg::*;
#(
   parameter int STANDSTILL_CYCLES = 2 ** STILL_EXP
) (
   input wire logic clk_in,
   input wire logic reset_n_in,
   input wire logic clk_en_in,
   input wire logic link_clk_in,
   input wire logic frame_n_in,
   input wire logic link_data_in,
   output logic link_data_out,
   output logic link_data_oe_n_out,
   input wire logic step_in,
   input wire logic driver_disable_pin_in,
   input wire logic supply_low_flag_in,
   input wire logic temp_detector_highest_in,
   input wire logic temp_detector_high_in,
   input wire logic temp_detector_mid_in,
   input wire logic temp_detector_low_in,
   input wire logic coil_b_short_supply_in,
   input wire logic coil_b_short_ground_in,
   input wire logic coil_a_short_supply_in,
   input wire logic coil_a_short_ground_in,
   input wire logic overtemp_warning_in,
   input wire logic overtemp_shutdown_in,
   input wire logic stall_detect_in,
   input wire logic [9:0] microstep_position_in,
   input wire logic [9:0] load_value_in,
   input wire logic [4:0] current_scale_value_in,
   input wire logic coil_b_polarity_in,
   input wire logic chopper_event_a_in,
   input wire logic chopper_event_b_in,
   input wire logic current_above_min_a_in,
   input wire logic current_above_min_b_in,
   output logic stall_output_pin_out,
   output logic power_stage_enable_out,
   output logic chopper_suspend_out,
   output logic step_input_disable_out
);
   typedef struct packed {
      logic [STATUS_W-1:0] driver_configuration;
      logic [CHOPPER_OFF_TIME_W-1:0] chopper_off_time;
      logic [STATUS_W-1:0] snap;
      logic [STILL_W-1:0] still_cnt;
      logic standstill;
      logic step_q;
      logic frame_q;
      logic [1:0] short_q;
      logic [1:0] pol_q;
      logic [1:0] seen;
      logic [1:0] open_load;
      logic [1:0] short_cnt;
      logic shutdown;
      logic power_en;
      logic suspend;
      logic stall;
   } dsr_state_type;

   dsr_state_type st_reg, st_next;
   dsr_pins_type pins;
   logic [STATUS_W-1:0] rx_word;
   logic [STATUS_W-1:0] status_word;
   logic [1:0] short_now, short_evt_v, pol_now, pol_chg, chop_evt;
   logic short_evt, pol_change, shut_clear, step_edge, frame_rise;
   logic [STILL_W-1:0] still_lim;

   // Temperatures cross here with the other pins
   dsr_sync #(
      .W($bits(dsr_pins_type)),
      .INIT(PINS_RESET)
   ) u_sync (
      .clk_in(clk_in),
      .reset_n_in(reset_n_in),
      .clk_en_in(clk_en_in),
      .async_in({frame_n_in, step_in, driver_disable_pin_in,
                 supply_low_flag_in, temp_detector_highest_in,
                 temp_detector_high_in, temp_detector_mid_in,
                 temp_detector_low_in, coil_b_short_supply_in,
                 coil_b_short_ground_in, coil_a_short_supply_in,
                 coil_a_short_ground_in, overtemp_warning_in,
                 overtemp_shutdown_in, stall_detect_in}),
      .sync_out(pins)
   );

   // Snapshot is frozen while the synchronised frame select is low, so the link reads it safely
   dsr_spi_link u_link (
      .link_clk_in(link_clk_in),
      .frame_n_in(frame_n_in),
      .link_data_in(link_data_in),
      .status_in(st_reg.snap),
      .link_data_out(link_data_out),
      .link_data_oe_n_out(link_data_oe_n_out),
      .word_out(rx_word)
   );

   function automatic logic [STATUS_W-1:0] build_status(
      input logic [1:0] sel,
      input dsr_pins_type p,
      input logic [9:0] microstep_position,
      input logic [9:0] load,
      input logic [4:0] scale,
      input logic still,
      input logic [1:0] ol,
      input logic stall
   );
      logic [9:0] upper;
      upper = microstep_position;
      unique case (dsr_readback_select_type'(sel))
         RD_POSITION: upper = microstep_position;
         RD_LOAD: upper = load;
         RD_LOAD_SCALE: upper = {load[9:5], scale};
         RD_DIAG: upper = {p.supply_low, p.disable_drv, p.b_supply,
                           p.b_ground, p.a_supply, p.a_ground,
                           p.temp};
      endcase
      // Lower field identical in every format except bit 9, the diagnostic marker
      return {upper, (sel == 2'(RD_DIAG)), 1'b0, still, ol[1], ol[0],
              (p.b_supply | p.b_ground), (p.a_supply | p.a_ground),
              p.overtemp_warning, p.ot, stall};
   endfunction

   assign still_lim = STILL_W'(STANDSTILL_CYCLES);
   assign short_now = {pins.b_supply | pins.b_ground,
                       pins.a_supply | pins.a_ground};
   assign short_evt_v = short_now & ~st_reg.short_q;
   assign short_evt = |short_evt_v;
   // Coil A polarity is the top position bit
   assign pol_now = {coil_b_polarity_in, microstep_position_in[9]};
   assign pol_chg = pol_now ^ st_reg.pol_q;
   assign pol_change = |pol_chg;
   assign chop_evt = {chopper_event_b_in & current_above_min_b_in,
                      chopper_event_a_in & current_above_min_a_in};
   assign shut_clear = pins.disable_drv || (st_reg.chopper_off_time == CHOPPER_OFF_TIME_RESET);
   assign step_edge = pins.step & ~st_reg.step_q;
   assign frame_rise = pins.frame_n & ~st_reg.frame_q;
   assign status_word = build_status(st_reg.driver_configuration[READBACK_SELECT_LSB +: 2], pins,
      microstep_position_in, load_value_in, current_scale_value_in,
      st_reg.standstill, st_reg.open_load, st_reg.stall);

   always_comb begin
      st_next = st_reg;
      if (clk_en_in) begin
         st_next.step_q = pins.step;
         st_next.frame_q = pins.frame_n;
         st_next.short_q = short_now;
         st_next.pol_q = pol_now;
         st_next.stall = pins.stall;
         // Command taken once the frame has closed
         if (frame_rise) begin
            unique case (rx_word[STATUS_W-1 -: 3])
               ADDR_DRIVER_CONFIGURATION: st_next.driver_configuration = rx_word;
               ADDR_CHOPPER: st_next.chopper_off_time = rx_word[CHOPPER_OFF_TIME_W-1:0];
               default: st_next.driver_configuration = st_reg.driver_configuration;
            endcase
         end
         // Refreshed only between frames
         if (pins.frame_n) begin
            st_next.snap = status_word;
         end
         // Saturating idle counter
         if (step_edge) begin
            st_next.still_cnt = '0;
         end else if (st_reg.still_cnt < still_lim) begin
            st_next.still_cnt = st_reg.still_cnt + STILL_W'(1);
         end
         st_next.standstill = (st_next.still_cnt >= still_lim);
         // Period closes on polarity change; event qualified by current
         for (int i = 0; i < 2; i++) begin
            if (pol_chg[i]) begin
               st_next.open_load[i] = ~(st_reg.seen[i] | chop_evt[i]);
               st_next.seen[i] = 1'b0;
            end else begin
               st_next.seen[i] = st_reg.seen[i] | chop_evt[i];
               if (chop_evt[i]) begin
                  st_next.open_load[i] = 1'b0;
               end
            end
         end
         // Short counter: up per short, down per polarity change
         if (shut_clear) begin
            st_next.short_cnt = short_evt ? 2'h1 : 2'h0;
         end else if (short_evt && !pol_change) begin
            if (st_reg.short_cnt != SHORT_LIMIT) begin
               st_next.short_cnt = st_reg.short_cnt + 2'h1;
            end
         end else if (pol_change && !short_evt) begin
            if (st_reg.short_cnt != 2'h0) begin
               st_next.short_cnt = st_reg.short_cnt - 2'h1;
            end
         end
         // Set wins over clear
         st_next.shutdown = (st_reg.short_cnt == SHORT_LIMIT) ||
                            (st_reg.shutdown && !shut_clear);
         // Open-load flags play no part here
         st_next.power_en = !st_next.shutdown && !shut_clear;
         st_next.suspend = |short_now;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         // Polarity seeded from inputs, so release shows no false change
         st_reg <= '{driver_configuration: DRIVER_CONFIGURATION_RESET, chopper_off_time: CHOPPER_OFF_TIME_RESET,
                     snap: STATUS_RESET, frame_q: 1'b1, pol_q: pol_now,
                     default: '0};
      end else begin
         st_reg <= st_next;
      end
   end

   assign stall_output_pin_out = st_reg.stall;
   assign power_stage_enable_out = st_reg.power_en;
   assign chopper_suspend_out = st_reg.suspend;
   assign step_input_disable_out = st_reg.driver_configuration[STEP_DIS_BIT];

   property p_diag_marker;
      @(posedge clk_in) disable iff (!reset_n_in)
      status_word[9] == (st_reg.driver_configuration[READBACK_SELECT_LSB +: 2] == 2'h3);
   endproperty
   a_diag_marker: assert property (p_diag_marker)
      else $error("bit 9 does not match diagnostic select");

   property p_load_format;
      @(posedge clk_in) disable iff (!reset_n_in)
      (st_reg.driver_configuration[READBACK_SELECT_LSB +: 2] == 2'h2) |->
         status_word[19:10] == {load_value_in[9:5], current_scale_value_in};
   endproperty
   a_load_format: assert property (p_load_format)
      else $error("load and scale format wrong");

   property p_position_format;
      @(posedge clk_in) disable iff (!reset_n_in)
      (st_reg.driver_configuration[READBACK_SELECT_LSB +: 2] == 2'h0) |->
         status_word[19:9] == {microstep_position_in, 1'b0};
   endproperty
   a_position_format: assert property (p_position_format)
      else $error("position format wrong");

   property p_step_clears_still;
      @(posedge clk_in) disable iff (!reset_n_in)
      (clk_en_in && step_edge) |=> !st_reg.standstill ##1
         (st_reg.still_cnt <= STILL_W'(2));
   endproperty
   a_step_clears_still: assert property (p_step_clears_still)
      else $error("standstill not cleared by step edge");

   property p_short_count;
      @(posedge clk_in) disable iff (!reset_n_in)
      (clk_en_in && short_evt && !pol_change && !shut_clear &&
       st_reg.short_cnt < SHORT_LIMIT) |=>
         st_reg.short_cnt == $past(st_reg.short_cnt) + 2'h1;
   endproperty
   a_short_count: assert property (p_short_count)
      else $error("short counter did not increment");

   property p_shutdown_at_limit;
      @(posedge clk_in) disable iff (!reset_n_in)
      (clk_en_in && st_reg.short_cnt == SHORT_LIMIT) |=>
         st_reg.shutdown && !power_stage_enable_out;
   endproperty
   a_shutdown_at_limit: assert property (p_shutdown_at_limit)
      else $error("outputs not off at short limit");

   property p_shutdown_release;
      @(posedge clk_in) disable iff (!reset_n_in)
      (st_reg.shutdown && !shut_clear) |-> !power_stage_enable_out;
   endproperty
   a_shutdown_release: assert property (p_shutdown_release)
      else $error("outputs on while shut down");

   property p_stall_pin;
      @(posedge clk_in) disable iff (!reset_n_in)
      clk_en_in |=> stall_output_pin_out == $past(pins.stall) &&
         stall_output_pin_out == status_word[0];
   endproperty
   a_stall_pin: assert property (p_stall_pin)
      else $error("stall pin differs from status bit 0");

   property p_open_load_set;
      @(posedge clk_in) disable iff (!reset_n_in)
      (clk_en_in && pol_chg[0] && !st_reg.seen[0] && !chop_evt[0]) |=>
         st_reg.open_load[0];
   endproperty
   a_open_load_set: assert property (p_open_load_set)
      else $error("coil A open load not flagged");

   property p_snap_frozen;
      @(posedge clk_in) disable iff (!reset_n_in)
      (!pins.frame_n && !$past(pins.frame_n)) |-> $stable(st_reg.snap);
   endproperty
   a_snap_frozen: assert property (p_snap_frozen)
      else $error("status snapshot changed during frame");
endmodule

// file: rtl/dsr_spi_link.sv
// Serial link shifter running on the controller's serial clock
`timescale 1ns/1ps
module dsr_spi_link
   import dsr_pkg::*;
(
   input wire logic link_clk_in,
   input wire logic frame_n_in,
   input wire logic link_data_in,
   input wire logic [STATUS_W-1:0] status_in,
   output logic link_data_out,
   output logic link_data_oe_n_out,
   output logic [STATUS_W-1:0] word_out
);
   logic [STATUS_W-1:0] rx_reg, rx_next;
   dsr_link_tx_type tx_reg, tx_next;

   // Keeps the last twenty bits; clock stands still between frames
   always_comb begin
      rx_next = {rx_reg[STATUS_W-2:0], link_data_in};
   end

   always_ff @(posedge link_clk_in) begin
      rx_reg <= rx_next;
   end

   // First falling edge loads the frozen word, MSB first
   always_comb begin
      tx_next = tx_reg;
      if (!tx_reg.started) begin
         tx_next.data = status_in[STATUS_W-1];
         tx_next.rest = status_in[STATUS_W-2:0];
         tx_next.started = 1'b1;
         tx_next.oe_n = 1'b0;
      end else begin
         tx_next.data = tx_reg.rest[STATUS_W-2];
         tx_next.rest = {tx_reg.rest[STATUS_W-3:0], 1'b0};
      end
   end

   // Frame select ends the frame, since no clock edge follows it
   always_ff @(negedge link_clk_in or posedge frame_n_in) begin
      if (frame_n_in) begin
         tx_reg <= LINK_TX_IDLE;
      end else begin
         tx_reg <= tx_next;
      end
   end

   assign link_data_out = tx_reg.data;
   assign link_data_oe_n_out = tx_reg.oe_n;
   assign word_out = rx_reg;
endmodule

// file: rtl/dsr_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module dsr_sync
   import dsr_pkg::*;
#(
   parameter int W = 16,
   parameter logic [W-1:0] INIT = '0
) (
   input wire logic clk_in,
   input wire logic reset_n_in,
   input wire logic clk_en_in,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] q;
   } dsr_sync_state_type;

   dsr_sync_state_type st_reg, st_next;

   // Stage one feeds stage two only; a bit moves once two and three agree
   always_comb begin
      st_next = st_reg;
      if (clk_en_in) begin
         st_next.s1 = async_in;
         st_next.s2 = st_reg.s1;
         st_next.s3 = st_reg.s2;
         st_next.q = (st_reg.s2 & ~(st_reg.s2 ^ st_reg.s3)) |
                     (st_reg.q & (st_reg.s2 ^ st_reg.s3));
      end
   end

   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         st_reg <= {INIT, INIT, INIT, INIT};
      end else begin
         st_reg <= st_next;
      end
   end

   assign sync_out = st_reg.q;
endmodule

// file: sim/dsr_ctl_model.sv
// Motion controller model acting as the serial master
`timescale 1ns/1ps
module dsr_ctl_model (
   output logic link_clk_out,
   output logic frame_n_out,
   output logic link_data_out,
   input wire logic link_data_in
);
   initial begin
      link_clk_out = 1'b1;
      // Pulsed once so the link shifter starts from its idle state
      frame_n_out = 1'b0;
      link_data_out = 1'b0;
      #1;
      frame_n_out = 1'b1;
   end

   // One command out, one status in, both MSB first
   task automatic xfer(input logic [19:0] cmd, output logic [19:0] rsp);
      rsp = 20'h00000;
      frame_n_out = 1'b0;
      // Setup gap, lets the status snapshot settle
      #120;
      for (int i = 19; i >= 0; i--) begin
         link_clk_out = 1'b0;
         link_data_out = cmd[i];
         #7.5;
         link_clk_out = 1'b1;
         rsp[i] = link_data_in;
         #7.5;
      end
      frame_n_out = 1'b1;
      // Released line shows the inverse, never a stale bit
      link_data_out = ~cmd[0];
      // Frame gap covers decode in the system domain
      #200;
   endtask
endmodule

// file: sim/tb_top.sv
// Self-checking bench for the driver status readback block
`timescale 1ns/1ps
module tb_top;
   import dsr_pkg::*;
   localparam int STILL = 16;
   localparam logic [19:0] CFG = 20'hE0000;
   localparam logic [19:0] MASK = 20'hFFE9F;
   localparam logic [19:0] INIT [5] = '{20'h901B4, 20'h94557,
      20'hD001F, 20'hE0010, 20'h00000};
   logic clk_in = 1'b0;
   logic reset_n_in = 1'b0;
   logic step_in = 1'b0;
   logic dis_pin = 1'b0;
   logic sup_low = 1'b1;
   logic [3:0] temp = 4'hA;
   logic [3:0] shorts = 4'h0;
   logic overtemp_warning = 1'b1;
   logic ot = 1'b0;
   logic stall = 1'b1;
   logic [9:0] msp = 10'h2A5;
   logic [9:0] load = 10'h1C3;
   logic [4:0] scale = 5'h15;
   logic pol_b = 1'b0;
   logic [1:0] ev = 2'h0;
   logic [1:0] above = 2'h0;
   logic clk_en = 1'b1;
   logic sck, frame_n, mosi, miso, oe_n, stall_pin, pwr, susp, sdis;
   logic [19:0] rsp;
   int failures = 0;
   int num_checks = 0;
   int cycles = 0;

   always #10 clk_in = ~clk_in;

   dsr_ctl_model i_dsr_ctl_model (
      .link_clk_out(sck), .frame_n_out(frame_n), .link_data_out(mosi),
      .link_data_in(miso));

   dsr_readback #(.STANDSTILL_CYCLES(STILL)) i_dsr_readback (
      .clk_in(clk_in), .reset_n_in(reset_n_in), .clk_en_in(clk_en),
      .link_clk_in(sck), .frame_n_in(frame_n), .link_data_in(mosi),
      .link_data_out(miso), .link_data_oe_n_out(oe_n), .step_in(step_in),
      .driver_disable_pin_in(dis_pin), .supply_low_flag_in(sup_low),
      .temp_detector_highest_in(temp[3]), .temp_detector_high_in(temp[2]),
      .temp_detector_mid_in(temp[1]), .temp_detector_low_in(temp[0]),
      .coil_b_short_supply_in(shorts[3]), .coil_b_short_ground_in(shorts[2]),
      .coil_a_short_supply_in(shorts[1]), .coil_a_short_ground_in(shorts[0]),
      .overtemp_warning_in(overtemp_warning), .overtemp_shutdown_in(ot),
      .stall_detect_in(stall), .microstep_position_in(msp),
      .load_value_in(load), .current_scale_value_in(scale),
      .coil_b_polarity_in(pol_b), .chopper_event_a_in(ev[0]),
      .chopper_event_b_in(ev[1]), .current_above_min_a_in(above[0]),
      .current_above_min_b_in(above[1]), .stall_output_pin_out(stall_pin),
      .power_stage_enable_out(pwr), .chopper_suspend_out(susp),
      .step_input_disable_out(sdis));

   task automatic summarize();
      if (failures == 0 && num_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic check(input logic [19:0] seen, input logic [19:0] exp);
      num_checks++;
      if (seen !== exp) begin
         failures++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk_in);
   endtask

   // Ends on a clock edge so callers can drive by NBA afterwards
   task automatic xfer(input logic [19:0] cmd);
      i_dsr_ctl_model.xfer(cmd, rsp);
      tick(1);
   endtask

   // Bounded wait for power enable and suspend to reach a pair
   task automatic poll(input logic p, input logic s);
      for (int i = 0; i < 20 && {pwr, susp} !== {p, s}; i++) begin
         tick(1);
      end
      check(20'({pwr, susp}), 20'({p, s}));
   endtask

   function automatic logic [19:0] expect_word(input logic [1:0] sel);
      logic [9:0] hi;
      case (sel)
         2'h0: hi = msp;
         2'h1: hi = load;
         2'h2: hi = {load[9:5], scale};
         default: hi = {sup_low, dis_pin, shorts, temp};
      endcase
      return {hi, sel == 2'h3, 2'b01, 2'b00, |shorts[3:2], |shorts[1:0],
         overtemp_warning, ot, stall};
   endfunction

   // Config write, then a second frame that reports in the new format
   task automatic read_sel(input logic [1:0] sel);
      xfer(CFG | (20'(sel) << READBACK_SELECT_LSB));
      xfer(CFG | (20'(sel) << READBACK_SELECT_LSB));
      // Reserved and open-load bits are left out here
      check(rsp & MASK, expect_word(sel) & MASK);
   endtask

   // Short on coil A; power expected to read p afterwards
   task automatic pulse_short(input logic p);
      shorts[0] <= 1'b1;
      tick(4);
      xfer(CFG);
      check(20'({pwr, susp, rsp[4:3]}), 20'({p, 3'b101}));
      shorts[0] <= 1'b0;
      tick(8);
      check(20'({pwr, susp}), 20'({p, 1'b0}));
   endtask

   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         summarize();
      end
   end

   initial begin
      tick(2);
      #1;
      check(20'({stall_pin, pwr, susp, sdis, oe_n, miso}), 20'h02);
      tick(1);
      reset_n_in <= 1'b1;
      tick(6);
      foreach (INIT[i]) xfer(INIT[i]);
      xfer(20'hA8202);
      xfer(20'h00000);
      check(rsp & MASK, expect_word(2'h1) & MASK);
      check(20'({sdis, oe_n, miso, stall_pin}), 20'h5);
      poll(1'b1, 1'b0);
      for (int s = 0; s < 4; s++) read_sel(2'(s));
      msp <= 10'h05A;
      read_sel(2'h0);
      xfer(CFG | 20'h00080);
      check(20'(sdis), 20'h1);
      xfer(CFG);
      step_in <= 1'b1;
      tick(3);
      step_in <= 1'b0;
      xfer(CFG);
      check(20'(rsp[7]), 20'h0);
      tick(STILL + 10);
      xfer(CFG);
      check(20'(rsp[7]), 20'h1);
      // Polarity change takes one count back, so four shorts trip
      pulse_short(1'b1);
      pulse_short(1'b1);
      pol_b <= ~pol_b;
      tick(2);
      pulse_short(1'b1);
      pulse_short(1'b0);
      xfer(20'h80000);
      poll(1'b0, 1'b0);
      xfer(20'h94557);
      poll(1'b1, 1'b0);
      for (int k = 0; k < 3; k++) pulse_short(k < 2);
      dis_pin <= 1'b1;
      tick(6);
      poll(1'b0, 1'b0);
      // Frozen clock enable must keep power off despite the release
      clk_en <= 1'b0;
      dis_pin <= 1'b0;
      tick(8);
      check(20'(pwr), 20'h0);
      clk_en <= 1'b1;
      poll(1'b1, 1'b0);
      // Slow polarity change with no coil B event opens the flag
      ot <= 1'b1;
      pol_b <= ~pol_b;
      tick(6);
      xfer(CFG);
      check(20'({rsp[6], pwr}), 20'h3);
      check(20'(rsp[2:0]), 20'h7);
      ev[1] <= 1'b1;
      tick(2);
      ev[1] <= 1'b0;
      xfer(CFG);
      check(20'(rsp[6]), 20'h1);
      above[1] <= 1'b1;
      ev[1] <= 1'b1;
      tick(2);
      ev[1] <= 1'b0;
      xfer(CFG);
      check(20'(rsp[6]), 20'h0);
      summarize();
   end
endmodule
